// ==== wis_frame_align_los.sv ====
// Framing octet insertion, receive frame aligner and signal loss alarms
module wis_frame_align_los #(
   parameter int FRAME_OCTETS = wis_frame_pkg::FRAME_OCTETS_DEF
) (
   input wire logic clk,               // Word clock, 125 MHz
   input wire logic rst,               // Async reset, active high
   input wire logic psel,              // APB select
   input wire logic penable,           // APB access phase
   input wire logic pwrite,            // APB write
   input wire logic [7:0] paddr,       // APB byte address
   input wire logic [31:0] pwdata,     // APB write data
   output logic [31:0] prdata,         // APB read data
   output logic pready,                // APB ready
   output logic pslverr,               // APB error, unmapped address
   input wire logic [7:0] tx_in_octet, // Transmit octet in
   input wire logic [1:0] tx_in_slot,  // Slot kind of that octet
   input wire logic tx_in_valid,       // Transmit strobe
   output logic [7:0] tx_out_octet,    // Transmit octet out
   output logic tx_out_valid,          // Transmit out strobe
   input wire logic [7:0] rx_in_octet, // Receive octet from PMA
   input wire logic rx_in_valid,       // Receive strobe
   output logic [7:0] rx_out_octet,    // Delivered receive octet
   output logic rx_out_valid,          // Delivered strobe
   output logic rx_frame_start,        // Pulse at first A2 of a frame
   input wire logic signal_loss_in,    // Loss of signal detect
   output logic sef_alarm,             // Severely errored frame
   output logic lof_alarm,             // Loss of frame
   output logic ais_l_alarm,           // AIS-L forced
   output logic in_sync,               // Aligner in sync
   output logic wan_irq_a,             // Interrupt A, level
   output logic wan_irq_b              // Interrupt B, level
);
   localparam int POS_W = $clog2(FRAME_OCTETS);

   // Frame must hold every pattern
   if (FRAME_OCTETS < 64)
      $error("FRAME_OCTETS too small");

   logic [31:0] ctrl_one_q, ctrl_one_d, ctrl_two_q, ctrl_two_d, tx_oct_q, tx_oct_d;
   logic [wis_frame_pkg::EV_W-1:0] pend_q, pend_d, ev_set, mask_a_q, mask_b_q;
   logic [wis_frame_pkg::EV_W-1:0] mask_a_d, mask_b_d;
   logic rdi_en_q, rdi_en_d, ais_en_q, ais_en_d;
   logic los_lat_q, los_lat_d, sef_lat_q, sef_lat_d, lof_lat_q, lof_lat_d;
   logic los_prev_q, oof_prev_q;
   logic [31:0] prdata_q, prdata_d, rd_mux;
   logic wr_en, rd_setup, rd_done, addr_ok;
   logic [4:0] f_raw, i_raw, j_raw, k_raw, f_eff, i_eff, j_eff, k_eff, sx, sy, chk_off;
   logic [3:0] entry_eff, exit_eff;
   logic is_a1, a2_in_run, nib_first;
   logic [4:0] a1_run, a1_prev, a2_idx;
   logic hunt_hit, presync_hit, sync_hit;
   wis_frame_pkg::frm_state_t state_q, state_d;
   wis_frame_pkg::sec_state_t sec_q, sec_d;
   logic [POS_W-1:0] pos_q, pos_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] tx_q, tx_d, rx_q, rx_d;
   logic tx_v_q, rx_v_q, fs_q, fs_d;

   // Pattern match: x A1s then y A2s, y zero means nibble only
   function automatic logic pat_match(input logic [4:0] x, input logic [4:0] y,
      input logic nib, input logic a2, input logic [4:0] prev, input logic [4:0] idx);
      logic hit;
      hit = 1'b0;
      if (y == 5'h00)
         hit = nib && (prev >= x);
      else
         hit = a2 && (idx == y - 5'h01) && (prev >= x);
      return hit;
   endfunction

   // Octet run tracking for the receive stream
   wis_frame_run_tracker u_tracker (
      .clk(clk),
      .rst(rst),
      .octet(rx_in_octet),
      .valid(rx_in_valid),
      .is_a1(is_a1),
      .a2_in_run(a2_in_run),
      .nib_first(nib_first),
      .a1_run(a1_run),
      .a1_prev(a1_prev),
      .a2_idx(a2_idx)
   );

   // Bus phase decode
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_done = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_q;

   // Effective framing settings with clamping
   always_comb
   begin
      f_raw = ctrl_one_q[wis_frame_pkg::F_LSB +: wis_frame_pkg::PAT_W];
      i_raw = ctrl_one_q[wis_frame_pkg::HUNT_LSB +: wis_frame_pkg::PAT_W];
      j_raw = ctrl_two_q[wis_frame_pkg::J_LSB +: wis_frame_pkg::PAT_W];
      k_raw = ctrl_two_q[wis_frame_pkg::K_LSB +: wis_frame_pkg::PAT_W];
      f_eff = (f_raw > wis_frame_pkg::PAT_MAX) ? wis_frame_pkg::PAT_MAX : f_raw;
      i_eff = (i_raw > wis_frame_pkg::PAT_MAX) ? wis_frame_pkg::PAT_MAX : i_raw;
      if (i_eff == 5'h00)
         i_eff = 5'h01;
      j_eff = (j_raw > wis_frame_pkg::PAT_MAX) ? wis_frame_pkg::PAT_MAX : j_raw;
      if (j_eff == 5'h00)
         j_eff = 5'h01;
      k_eff = (k_raw > wis_frame_pkg::PAT_MAX) ? wis_frame_pkg::PAT_MAX : k_raw;
      entry_eff = ctrl_two_q[wis_frame_pkg::ENTRY_LSB +: wis_frame_pkg::CNT_W];
      if (entry_eff == 4'h0)
         entry_eff = 4'h1;
      exit_eff = ctrl_two_q[wis_frame_pkg::EXIT_LSB +: wis_frame_pkg::CNT_W];
      if (exit_eff == 4'h0)
         exit_eff = 4'h1;
      // sync pattern shapes for widths 0 and 1
      sx = f_eff;
      sy = f_eff;
      if (f_eff == 5'h00)
         sx = 5'h01;
      else if (f_eff == 5'h01)
         sx = 5'h02;
      chk_off = (sy == 5'h00) ? 5'h00 : sy - 5'h01;
      hunt_hit = is_a1 && (({1'b0, a1_run} + 6'h01) >= {1'b0, i_eff});
      // presync j A1s then k A2s
      presync_hit = pat_match(j_eff, k_eff, nib_first, a2_in_run, a1_prev, a2_idx);
      sync_hit = pat_match(sx, sy, nib_first, a2_in_run, a1_prev, a2_idx);
   end

   always_comb
   begin
      state_d = state_q;
      sec_d = sec_q;
      cnt_d = cnt_q;
      pos_d = pos_q;
      fs_d = 1'b0;
      if (rx_in_valid)
      begin
         pos_d = (pos_q == POS_W'(FRAME_OCTETS - 1)) ? '0 : pos_q + 1'b1;
         fs_d = (sec_q == wis_frame_pkg::SEC_LOCKED) && (pos_q == '0);
         case (state_q)
            wis_frame_pkg::ST_HUNT:
            begin
               sec_d = wis_frame_pkg::SEC_SEEK;
               cnt_d = 5'h00;
               if (hunt_hit)
                  state_d = wis_frame_pkg::ST_PRESYNC;
            end
            wis_frame_pkg::ST_PRESYNC:
            begin
               if (sec_q == wis_frame_pkg::SEC_SEEK)
               begin
                  if (presync_hit)
                  begin
                     // First boundary fixes the octet position
                     sec_d = wis_frame_pkg::SEC_LOCKED;
                     pos_d = POS_W'((k_eff == 5'h00) ? 5'h01 : k_eff);
                     cnt_d = 5'h01;
                  end
                  else if (!is_a1 && !a2_in_run && !nib_first)
                     state_d = wis_frame_pkg::ST_HUNT;
               end
               else if (pos_q == POS_W'(chk_off))
               begin
                  if (!sync_hit)
                     state_d = wis_frame_pkg::ST_HUNT;
                  else if (cnt_q >= {1'b0, entry_eff})
                  begin
                     state_d = wis_frame_pkg::ST_SYNC;
                     cnt_d = 5'h00;
                  end
                  else
                     cnt_d = cnt_q + 5'h01;
               end
            end
            wis_frame_pkg::ST_SYNC:
            begin
               if (pos_q == POS_W'(chk_off))
               begin
                  if (sync_hit)
                     cnt_d = 5'h00;
                  else if ((cnt_q + 5'h01) >= {1'b0, exit_eff})
                     state_d = wis_frame_pkg::ST_HUNT;
                  else
                     cnt_d = cnt_q + 5'h01;
               end
            end
            default:
               state_d = wis_frame_pkg::ST_HUNT;
         endcase
         if (state_d == wis_frame_pkg::ST_HUNT && state_q != wis_frame_pkg::ST_HUNT)
         begin
            sec_d = wis_frame_pkg::SEC_SEEK;
            cnt_d = 5'h00;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= wis_frame_pkg::ST_HUNT;
         sec_q <= wis_frame_pkg::SEC_SEEK;
         cnt_q <= 5'h00;
         pos_q <= '0;
         fs_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         sec_q <= sec_d;
         cnt_q <= cnt_d;
         pos_q <= pos_d;
         fs_q <= fs_d;
      end
   end

   assign in_sync = (state_q == wis_frame_pkg::ST_SYNC);
   assign rx_frame_start = fs_q;

   // Read mux and address decode
   always_comb
   begin
      addr_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         wis_frame_pkg::ADDR_CTRL_ONE: rd_mux = ctrl_one_q;
         wis_frame_pkg::ADDR_CTRL_TWO: rd_mux = ctrl_two_q;
         wis_frame_pkg::ADDR_TX_OCTETS: rd_mux = tx_oct_q;
         wis_frame_pkg::ADDR_STATUS:
         begin
            rd_mux[wis_frame_pkg::ST_LOS_BIT] = los_lat_q;
            rd_mux[wis_frame_pkg::ST_SEF_BIT] = sef_lat_q;
            rd_mux[wis_frame_pkg::ST_LOF_BIT] = lof_lat_q;
            rd_mux[wis_frame_pkg::ST_AIS_BIT] = ais_l_alarm;
            rd_mux[wis_frame_pkg::ST_SYNC_BIT] = in_sync;
         end
         wis_frame_pkg::ADDR_PENDING: rd_mux[wis_frame_pkg::EV_W-1:0] = pend_q;
         wis_frame_pkg::ADDR_MASK:
         begin
            rd_mux[wis_frame_pkg::MASK_A_LSB +: wis_frame_pkg::EV_W] = mask_a_q;
            rd_mux[wis_frame_pkg::MASK_B_LSB +: wis_frame_pkg::EV_W] = mask_b_q;
         end
         wis_frame_pkg::ADDR_ACTION:
         begin
            rd_mux[wis_frame_pkg::ACT_RDI_BIT] = rdi_en_q;
            rd_mux[wis_frame_pkg::ACT_AIS_BIT] = ais_en_q;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // Register writes, latches and pending bits; set beats clear
   always_comb
   begin
      ctrl_one_d = ctrl_one_q;
      ctrl_two_d = ctrl_two_q;
      tx_oct_d = tx_oct_q;
      mask_a_d = mask_a_q;
      mask_b_d = mask_b_q;
      rdi_en_d = rdi_en_q;
      ais_en_d = ais_en_q;
      prdata_d = rd_setup ? rd_mux : prdata_q;
      if (wr_en && paddr == wis_frame_pkg::ADDR_CTRL_ONE)
         ctrl_one_d = pwdata;
      if (wr_en && paddr == wis_frame_pkg::ADDR_CTRL_TWO)
         ctrl_two_d = pwdata;
      if (wr_en && paddr == wis_frame_pkg::ADDR_TX_OCTETS)
         tx_oct_d = pwdata;
      if (wr_en && paddr == wis_frame_pkg::ADDR_MASK)
      begin
         mask_a_d = pwdata[wis_frame_pkg::MASK_A_LSB +: wis_frame_pkg::EV_W];
         mask_b_d = pwdata[wis_frame_pkg::MASK_B_LSB +: wis_frame_pkg::EV_W];
      end
      if (wr_en && paddr == wis_frame_pkg::ADDR_ACTION)
      begin
         rdi_en_d = pwdata[wis_frame_pkg::ACT_RDI_BIT];
         ais_en_d = pwdata[wis_frame_pkg::ACT_AIS_BIT];
      end
      // latch high, read clears only what was shown
      los_lat_d = signal_loss_in || (los_lat_q && !(rd_done && paddr == wis_frame_pkg::ADDR_STATUS
         && prdata_q[wis_frame_pkg::ST_LOS_BIT]));
      sef_lat_d = !in_sync || (sef_lat_q && !(rd_done && paddr == wis_frame_pkg::ADDR_STATUS
         && prdata_q[wis_frame_pkg::ST_SEF_BIT]));
      lof_lat_d = !in_sync || (lof_lat_q && !(rd_done && paddr == wis_frame_pkg::ADDR_STATUS
         && prdata_q[wis_frame_pkg::ST_LOF_BIT]));
      // pending set on event, cleared by read or write-one
      ev_set = '0;
      ev_set[wis_frame_pkg::EV_LOS_BIT] = signal_loss_in && !los_prev_q;
      ev_set[wis_frame_pkg::EV_SEF_BIT] = !in_sync && !oof_prev_q;
      pend_d = pend_q;
      if (rd_done && paddr == wis_frame_pkg::ADDR_PENDING)
         pend_d = pend_q & ~prdata_q[wis_frame_pkg::EV_W-1:0];
      if (wr_en && paddr == wis_frame_pkg::ADDR_PENDING)
         pend_d = pend_d & ~pwdata[wis_frame_pkg::EV_W-1:0];
      pend_d = pend_d | ev_set;
   end

   // Register file and alarm latches
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // Settings come up at their defaults
         ctrl_one_q <= {19'h0_0000, wis_frame_pkg::HUNT_RST, 3'h0, wis_frame_pkg::F_RST};
         ctrl_two_q <= {4'h0, wis_frame_pkg::EXIT_RST, 4'h0, wis_frame_pkg::ENTRY_RST,
            3'h0, wis_frame_pkg::K_RST, 3'h0, wis_frame_pkg::J_RST};
         tx_oct_q <= {16'h0000, wis_frame_pkg::TX_SECOND_FRAMING_OCTET_RST, wis_frame_pkg::TX_FIRST_FRAMING_OCTET_RST};
         mask_a_q <= '0;
         mask_b_q <= '0;
         rdi_en_q <= 1'b0;
         ais_en_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         los_lat_q <= 1'b0;
         sef_lat_q <= 1'b1;
         lof_lat_q <= 1'b1;
         pend_q <= '0;
         los_prev_q <= 1'b0;
         oof_prev_q <= 1'b1;
      end
      else
      begin
         ctrl_one_q <= ctrl_one_d;
         ctrl_two_q <= ctrl_two_d;
         tx_oct_q <= tx_oct_d;
         mask_a_q <= mask_a_d;
         mask_b_q <= mask_b_d;
         rdi_en_q <= rdi_en_d;
         ais_en_q <= ais_en_d;
         prdata_q <= prdata_d;
         los_lat_q <= los_lat_d;
         sef_lat_q <= sef_lat_d;
         lof_lat_q <= lof_lat_d;
         pend_q <= pend_d;
         los_prev_q <= signal_loss_in;
         oof_prev_q <= !in_sync;
      end
   end

   assign wan_irq_a = |(pend_q & mask_a_q);
   assign wan_irq_b = |(pend_q & mask_b_q);
   // alarms active while out of frame
   assign sef_alarm = !in_sync;
   assign lof_alarm = !in_sync;
   // AIS-L on signal loss when enabled
   assign ais_l_alarm = ais_en_q && signal_loss_in;

   // Datapath next values, transmit and receive
   always_comb
   begin
      tx_d = tx_in_octet;
      case (tx_in_slot)
         wis_frame_pkg::SLOT_A1: tx_d = tx_oct_q[wis_frame_pkg::TXA1_LSB +: 8];
         wis_frame_pkg::SLOT_A2: tx_d = tx_oct_q[wis_frame_pkg::TXA2_LSB +: 8];
         wis_frame_pkg::SLOT_K2:
         begin
            // RDI code in low K2 bits
            if (rdi_en_q && signal_loss_in)
               tx_d = {tx_in_octet[7:3], wis_frame_pkg::K2_RDI};
         end
         default: tx_d = tx_in_octet;
      endcase
      rx_d = ais_l_alarm ? wis_frame_pkg::ALL_ONES : rx_in_octet;
   end

   // Datapath registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         tx_v_q <= 1'b0;
         rx_v_q <= 1'b0;
      end
      else
      begin
         tx_q <= tx_in_valid ? tx_d : tx_q;
         rx_q <= rx_in_valid ? rx_d : rx_q;
         tx_v_q <= tx_in_valid;
         rx_v_q <= rx_in_valid;
      end
   end

   assign tx_out_octet = tx_q;
   assign tx_out_valid = tx_v_q;
   assign rx_out_octet = rx_q;
   assign rx_out_valid = rx_v_q;
endmodule

// ==== wis_frame_run_tracker.sv ====
// Framing constants package and the receive A1/A2 run tracker
// Behaviour
// - Every transmit A1 slot takes the first octet field, every A2 the second.
// - Delineation matches A1 as 0xf6 and A2 as 0x28.
// - Receive aligner finds frame boundaries using a primary and secondary state machine.
// - Sync width f 0..16, default 2; 0 is A1 plus A2 nibble, 1 is A1A1A2.
// - Hunt pattern is i consecutive A1s, 1 to 16, default 4.
// - Presync is j A1s then k A2s, default 16; j 0 acts 1; 17..31 act 16.
// - Sync entry and exit counts 1..15, default 4; zero acts as one.
// - Framing settings live in two control registers, rewritable at any time.
// - Signal loss status latches high; second read shows current condition.
// - A signal loss event sets a pending bit held until software reads it or writes one to it.
// - Pending bit drives interrupt A or B through separate mask bits.
// - Signal loss detection uses no hysteresis; software qualifies it.
// - With RDI enable and signal loss, outgoing K2 carries the RDI code.
// - With AIS enable and signal loss, raise AIS-L and send all-ones payload.
// - After reset the framer is out of frame with SEF and LOF active.
// - Sync state entered after entry count plus one consecutive boundaries.
package wis_frame_pkg;
   // Framing octets for delineation
   // fixed receive octets, transmit octet reset values
   localparam logic [7:0] RX_A1 = 8'hf6;
   localparam logic [7:0] RX_A2 = 8'h28;
   localparam logic [7:0] TX_FIRST_FRAMING_OCTET_RST = 8'hf6;
   localparam logic [7:0] TX_SECOND_FRAMING_OCTET_RST = 8'h28;
   // Pattern and count fields
   localparam int PAT_W = 5;
   localparam int CNT_W = 4;
   localparam logic [4:0] PAT_MAX = 5'h10;
   localparam logic [4:0] F_RST = 5'h02;
   localparam logic [4:0] HUNT_RST = 5'h04;
   localparam logic [4:0] J_RST = 5'h10;
   localparam logic [4:0] K_RST = 5'h10;
   localparam logic [3:0] ENTRY_RST = 4'h4;
   localparam logic [3:0] EXIT_RST = 4'h4;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_TX_OCTETS = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_PENDING = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_ACTION = 8'h18;
   // Field positions
   localparam int F_LSB = 0;
   localparam int HUNT_LSB = 8;
   localparam int J_LSB = 0;
   localparam int K_LSB = 8;
   localparam int ENTRY_LSB = 16;
   localparam int EXIT_LSB = 24;
   localparam int TXA1_LSB = 0;
   localparam int TXA2_LSB = 8;
   localparam int ST_LOS_BIT = 0;
   localparam int ST_SEF_BIT = 1;
   localparam int ST_LOF_BIT = 2;
   localparam int ST_AIS_BIT = 3;
   localparam int ST_SYNC_BIT = 4;
   localparam int EV_LOS_BIT = 0;
   localparam int EV_SEF_BIT = 1;
   localparam int EV_W = 2;
   localparam int MASK_A_LSB = 0;
   localparam int MASK_B_LSB = 8;
   localparam int ACT_RDI_BIT = 0;
   localparam int ACT_AIS_BIT = 1;
   // K2 line RDI code in the low bits
   localparam logic [2:0] K2_RDI = 3'b110;
   localparam logic [7:0] ALL_ONES = 8'hff;
   // Octets per frame
   localparam int FRAME_OCTETS_DEF = 155520;
   typedef enum logic [1:0] {SLOT_DATA, SLOT_A1, SLOT_A2, SLOT_K2} tx_slot_t;
   typedef enum logic [1:0] {ST_HUNT, ST_PRESYNC, ST_SYNC} frm_state_t;
   typedef enum logic {SEC_SEEK, SEC_LOCKED} sec_state_t;
endpackage

module wis_frame_run_tracker (
   input wire logic clk,               // Word clock
   input wire logic rst,               // Async reset
   input wire logic [7:0] octet,       // Receive octet
   input wire logic valid,             // Octet strobe
   output logic is_a1,                 // Octet is A1
   output logic a2_in_run,             // A2 following A1s
   output logic nib_first,             // First A2 slot, high nibble matches
   output logic [4:0] a1_run,          // A1s seen before this octet
   output logic [4:0] a1_prev,         // A1s ahead of the A2 run
   output logic [4:0] a2_idx           // Index within the A2 run
);
   logic [4:0] run_q, run_d, prev_q, prev_d, a2cnt_q, a2cnt_d;

   // Classify current octet against history
   always_comb
   begin
      is_a1 = (octet == wis_frame_pkg::RX_A1);
      a2_in_run = (octet == wis_frame_pkg::RX_A2) && ((a2cnt_q != 5'h00) || (run_q != 5'h00));
      nib_first = (octet[7:4] == wis_frame_pkg::RX_A2[7:4]) && (a2cnt_q == 5'h00)
         && (run_q != 5'h00);
      a1_run = run_q;
      a1_prev = (a2cnt_q == 5'h00) ? run_q : prev_q;
      a2_idx = a2cnt_q;
   end

   // Next run counts, saturating at the widest pattern
   always_comb
   begin
      run_d = run_q;
      prev_d = prev_q;
      a2cnt_d = a2cnt_q;
      if (valid)
      begin
         if (is_a1)
         begin
            run_d = (run_q == wis_frame_pkg::PAT_MAX) ? run_q : run_q + 5'h01;
            a2cnt_d = 5'h00;
         end
         else if (a2_in_run)
         begin
            if (a2cnt_q == 5'h00)
               prev_d = run_q;
            a2cnt_d = (a2cnt_q == wis_frame_pkg::PAT_MAX) ? a2cnt_q : a2cnt_q + 5'h01;
            run_d = 5'h00;
         end
         else
         begin
            run_d = 5'h00;
            prev_d = 5'h00;
            a2cnt_d = 5'h00;
         end
      end
   end

   // Run registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         run_q <= 5'h00;
         prev_q <= 5'h00;
         a2cnt_q <= 5'h00;
      end
      else
      begin
         run_q <= run_d;
         prev_q <= prev_d;
         a2cnt_q <= a2cnt_d;
      end
   end
endmodule

// ==== wis_frame_align_los_assertions.sv ====
// Port checker for the framer and signal loss block
module wis_frame_align_los_assertions (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic psel, // In
   input wire logic penable, // In
   input wire logic pready, // Out
   input wire logic pslverr, // Out
   input wire logic [7:0] tx_in_octet, // In
   input wire logic [1:0] tx_in_slot, // In
   input wire logic tx_in_valid, // In
   input wire logic [7:0] tx_out_octet, // Out
   input wire logic tx_out_valid, // Out
   input wire logic [7:0] rx_in_octet, // In
   input wire logic rx_in_valid, // In
   input wire logic [7:0] rx_out_octet, // Out
   input wire logic rx_out_valid, // Out
   input wire logic signal_loss_in, // In
   input wire logic ais_l_alarm, // Out
   input wire logic sef_alarm, // Out
   input wire logic lof_alarm, // Out
   input wire logic in_sync // Out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Transmit octet taken
   sequence s_tx_take;
      tx_in_valid;
   endsequence
   property p_tx_strobe; s_tx_take |=> tx_out_valid; endproperty
   a_tx_strobe: assert property (p_tx_strobe) else $error("tx strobe lost");
   property p_tx_data;
      s_tx_take ##0 tx_in_slot == 2'h0 |=> tx_out_octet == $past(tx_in_octet);
   endproperty
   a_tx_data: assert property (p_tx_data) else $error("tx data altered");
   property p_k2_upper;
      s_tx_take ##0 tx_in_slot == 2'h3 |=> tx_out_octet[7:3] == $past(tx_in_octet[7:3]);
   endproperty
   a_k2_upper: assert property (p_k2_upper) else $error("K2 upper bits altered");
   property p_ais_cause; ais_l_alarm |-> signal_loss_in; endproperty
   a_ais_cause: assert property (p_ais_cause) else $error("AIS-L without loss");
   property p_ais_ones; rx_in_valid && ais_l_alarm |=> rx_out_octet == 8'hff; endproperty
   a_ais_ones: assert property (p_ais_ones) else $error("payload not all ones");
   property p_rx_pass;
      rx_in_valid && !ais_l_alarm |=> rx_out_valid && rx_out_octet == $past(rx_in_octet);
   endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("rx octet altered");
   property p_oof; !in_sync |-> sef_alarm && lof_alarm; endproperty
   a_oof: assert property (p_oof) else $error("out of frame alarms low");
   property p_sync; in_sync |-> !sef_alarm && !lof_alarm; endproperty
   a_sync: assert property (p_sync) else $error("alarms high in sync");
   property p_apb; psel && penable |-> pready; endproperty
   a_apb: assert property (p_apb) else $error("no ready in access");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
endmodule
bind wis_frame_align_los wis_frame_align_los_assertions i_wis_frame_align_los_assertions (.*);

// ==== wis_pma_model.sv ====
// Receive stream source sending A1/A2 framed octets
module wis_pma_model #(
   parameter int FRAME_OCTETS = 200
) (
   input wire logic clk, // Clock
   input wire logic en, // Send frames
   input wire logic bad, // Corrupt A2 octets
   output logic [7:0] octet, // Stream octet
   output logic valid // Stream strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos_q = 0;
   initial octet = 8'h00;
   initial valid = 1'b0;
   always @(posedge clk)
   begin
      valid <= en;
      pos_q <= (!en || pos_q == FRAME_OCTETS - 1) ? 0 : pos_q + 1;
      if (!en)
         octet <= ~octet;
      else if (pos_q < 16)
         octet <= wis_frame_pkg::RX_A1;
      else if (pos_q < 32)
         octet <= bad ? 8'h00 : wis_frame_pkg::RX_A2;
      else
         octet <= 8'h00;
   end
endmodule

// ==== wis_frame_align_los_tb.sv ====
// Self-checking bench for the framer and signal loss block
module wis_frame_align_los_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FO = 200;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tx_in_valid = 0;
   logic signal_loss_in = 0, en = 0, bad = 0, e;
   logic [7:0] paddr = 8'h0, tx_in_octet = 8'h0, rx_in_octet, tx_out_octet, rx_out_octet;
   logic [31:0] pwdata = 32'h0, prdata, r, v;
   logic [15:0] oct;
   logic [1:0] tx_in_slot = 2'h0;
   logic pready, pslverr, tx_out_valid, rx_in_valid, rx_out_valid, rx_frame_start;
   logic sef_alarm, lof_alarm, ais_l_alarm, in_sync, wan_irq_a, wan_irq_b;
   int seed, n, miscompares = 0, n_tests = 0;
   wis_frame_align_los #(.FRAME_OCTETS(FO)) i_wis_frame_align_los (.*);
   wis_pma_model #(.FRAME_OCTETS(FO)) i_wis_pma_model (.clk(clk), .en(en), .bad(bad),
      .octet(rx_in_octet), .valid(rx_in_valid));
   always #4 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, entered just after an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(r & m, exp);
   endtask
   function automatic logic [7:0] exp_tx(input logic [1:0] s, input logic [7:0] d,
      input logic rdi);
      case (s)
         2'h1: return oct[7:0];
         2'h2: return oct[15:8];
         2'h3: return rdi ? {d[7:3], 3'h6} : d;
         default: return d;
      endcase
   endfunction
   task automatic tx(input logic [1:0] s, input logic rdi);
      v = $random(seed);
      tx_in_slot <= s;
      tx_in_octet <= v[7:0];
      tx_in_valid <= 1'b1;
      @(posedge clk);
      tx_in_valid <= 1'b0;
      @(posedge clk);
      chk({23'h0, tx_out_valid, tx_out_octet}, {24'h1, exp_tx(s, v[7:0], rdi)});
   endtask
   task automatic wait_sync(input logic lvl);
      n = 0;
      while (in_sync !== lvl && n < 40 * FO)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #400000;
      miscompares++;
      final_report();
   end
   // Main sequence
   initial
   begin
      seed = 32'h14c79856;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h00, 32'h0402, '1);
      rd(8'h04, 32'h0404_1010, '1);
      rd(8'h0c, 32'h6, '1);
      rd(8'h10, 32'h0, 32'h1);
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 8'h00, 32'h0310);
      rd(8'h00, 32'h0310, '1);
      apb(1'b1, 8'h00, 32'h0402);
      v = $random(seed);
      oct = v[15:0];
      apb(1'b1, 8'h08, {16'h0, oct});
      for (int s = 0; s < 4; s++)
         tx(s[1:0], 1'b0);
      apb(1'b1, 8'h14, 32'h1);
      apb(1'b1, 8'h18, 32'h3);
      signal_loss_in <= 1'b1;
      repeat (2) @(posedge clk);
      chk({29'h0, wan_irq_b, wan_irq_a, ais_l_alarm}, 32'h3);
      tx(2'h3, 1'b1);
      rd(8'h0c, 32'h9, 32'h9);
      rd(8'h10, 32'h1, 32'h1);
      rd(8'h10, 32'h0, 32'h1);
      apb(1'b1, 8'h14, 32'h100);
      signal_loss_in <= 1'b0;
      @(posedge clk);
      chk({31'h0, ais_l_alarm}, 32'h0);
      signal_loss_in <= 1'b1;
      repeat (2) @(posedge clk);
      chk({30'h0, wan_irq_b, wan_irq_a}, 32'h2);
      signal_loss_in <= 1'b0;
      @(posedge clk);
      rd(8'h0c, 32'h1, 32'h1);
      rd(8'h0c, 32'h0, 32'h1);
      rd(8'h10, 32'h1, 32'h1);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h04, 32'h0404_1f1f);
      en <= 1'b1;
      wait_sync(1'b1);
      chk({31'h0, in_sync}, 32'h1);
      chk({31'h0, n >= 4 * FO}, 32'h1);
      // Frame start pulse marks the first A2 octet
      n = 0;
      while (rx_frame_start !== 1'b1 && n < 2 * FO)
      begin
         @(posedge clk);
         n++;
      end
      chk({23'h0, rx_out_valid, rx_out_octet}, {24'h1, wis_frame_pkg::RX_A2});
      bad <= 1'b1;
      wait_sync(1'b0);
      chk({30'h0, sef_alarm, n >= 3 * FO && n <= 5 * FO}, 32'h3);
      @(posedge clk);
      rd(8'h10, 32'h2, 32'h2);
      final_report();
   end
endmodule
